// ==== core/crtc_extended_cursor_regs.sv ====
// indexed bank of extended display timing, system and hardware cursor registers
//
// Contract
// R1: restart value is nine bits, top from extension
// R2: restart value used only while compat bit 4 set
// R3: restart counts character clocks from display start
// R4: software keeps restart inside horizontal blanking
// R5: interlace start offsets even/odd active display
// R6: interlace bit five selects interlaced, gates offset
// R7: system configuration bit zero gates enhanced access
// R8: ready bit four chooses zero or one wait
// R9: system configuration resets 30H, bit5 one
// R10: width bit eight ignored unless extension 00b
// R11: extended bit seven doubles horizontal timing
// R12: cursor shown only if enabled and enhanced
// R13: right storage option moves cursor to line end
// R14: software sets start low bits 11b then
// R15: cursor X is eleven bits, split high/low
// R16: X and Y applied together on Y high write
// R17: foreground stack three bytes, pointer advances
// R18: background shares pointer; mode read clears it
// R19: storage start is twelve bits, split high/low
// R20: six bit pattern column offset
// R21: six bit pattern row offset
// R22: firmware byte is plain storage, resets zero
// R23: coordinate bytes shadowed until Y high write
module crtc_extended_cursor_regs
    import crtc_ext_pkg::*;
(
    // clock and raw reset
    input  wire logic       i_clock,
    input  wire logic       i_resetn,

    // index/data port, one access per strobe cycle
    input  wire logic [7:0] i_index,
    input  wire logic       i_write,
    input  wire logic       i_read,
    input  wire logic [7:0] i_write_data,

    // levels from neighbouring registers and modes
    input  wire logic       i_compat_control_three_bit4,
    input  wire logic       i_horizontal_overflow_ext_bit6,
    input  wire logic [1:0] i_system_control_two_width,
    input  wire logic       i_enhanced_mode_active,
    // pixel depth is kept for the cursor generator; this bank does not use it
    input  wire logic       i_eight_bpp,

    // register contents and derived controls
    output logic [7:0]      o_read_data,
    output logic            o_index_hit,
    output logic            o_enhanced_access_enable,
    output logic            o_ready_wait_control,
    output timing_ctrl_t    o_timing,
    output cursor_ctrl_t    o_cursor
);

    // reset release chain
    logic         reset_sync1_ff;
    logic         reset_sync2_ff;
    logic         rst_n;

    // display timing, system and cursor mode bytes
    logic [7:0]   fifo_restart_low_ff;
    logic [7:0]   interlace_start_ff;
    logic [7:0]   system_config_ff;
    logic [7:0]   firmware_scratch_byte_ff;
    logic [7:0]   interlace_mode_ff;
    logic [7:0]   extended_mode_ff;
    logic [7:0]   cursor_mode_ff;

    // position shadows, Y high byte and live coordinates
    logic [7:0]   x_high_shadow_ff;
    logic [7:0]   x_low_shadow_ff;
    logic [7:0]   y_low_shadow_ff;
    logic [7:0]   y_high_ff;
    logic [10:0]  cursor_x_ff;
    logic [10:0]  cursor_y_ff;

    // colour stacks and their shared pointer
    logic [1:0]   stack_ptr_ff;
    logic [1:0]   nxt_stack_ptr;
    logic [7:0]   fg_stack_ff [3];
    logic [7:0]   bg_stack_ff [3];

    // storage start address and pattern offset bytes
    logic [7:0]   start_high_ff;
    logic [7:0]   start_low_ff;
    logic [7:0]   pattern_col_ff;
    logic [7:0]   pattern_row_ff;

    // stack write strobes
    logic         wr_fg;
    logic         wr_bg;

    // reset released through two flops so all state leaves reset on one edge;
    // assertion stays asynchronous, so the bank clears even with no clock
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            reset_sync1_ff <= 1'b0;
            reset_sync2_ff <= 1'b0;
        end else begin
            reset_sync1_ff <= 1'b1;
            reset_sync2_ff <= reset_sync1_ff;
        end
    end
    assign rst_n = reset_sync2_ff;

    // display timing, system and cursor mode bytes
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            fifo_restart_low_ff      <= BYTE_ZERO;
            interlace_start_ff       <= BYTE_ZERO;
            system_config_ff         <= SYSCFG_RESET;                // [R9]
            firmware_scratch_byte_ff <= BYTE_ZERO;                   // [R22]
            interlace_mode_ff        <= BYTE_ZERO;
            extended_mode_ff         <= BYTE_ZERO;
            cursor_mode_ff           <= BYTE_ZERO;
        end else if (i_write) begin
            // indices of the other groups fall to default and change nothing here
            case (i_index)
                IDX_FIFO_RESTART_LOW: fifo_restart_low_ff <= i_write_data;
                IDX_INTERLACE_START:  interlace_start_ff  <= i_write_data;
                // reserved bit 5 stays one, bits 7-6 stay zero
                IDX_SYSTEM_CONFIG:    system_config_ff <=
                    (i_write_data & SYSCFG_RW_MASK) | SYSCFG_FIXED_ONES;  // [R9]
                IDX_FIRMWARE_FLAG:    firmware_scratch_byte_ff <= i_write_data; // [R22]
                // mode bytes keep only their defined bits; the rest reads zero
                IDX_INTERLACE_MODE:   interlace_mode_ff <= i_write_data & INTERLACE_SELECT_MASK;
                IDX_EXTENDED_MODE:    extended_mode_ff  <= i_write_data & EXT_MODE_MASK;
                IDX_CURSOR_MODE:      cursor_mode_ff    <= i_write_data & CURSOR_MODE_MASK;
                default: ;
            endcase
        end
    end

    // cursor position: bytes land in shadows, the Y high write commits both axes;
    // software may write the other three bytes in any order before Y high and the cursor never jumps
    // to a half-updated spot, at the cost of one more byte write per move
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            x_high_shadow_ff <= BYTE_ZERO;
            x_low_shadow_ff  <= BYTE_ZERO;
            y_low_shadow_ff  <= BYTE_ZERO;
            y_high_ff        <= BYTE_ZERO;
            cursor_x_ff      <= '0;
            cursor_y_ff      <= '0;
        end else if (i_write) begin
            case (i_index)
                IDX_CURSOR_X_HIGH: x_high_shadow_ff <= i_write_data & HIGH3_MASK; // [R15] [R23]
                IDX_CURSOR_X_LOW:  x_low_shadow_ff  <= i_write_data;              // [R23]
                IDX_CURSOR_Y_LOW:  y_low_shadow_ff  <= i_write_data;              // [R23]
                IDX_CURSOR_Y_HIGH: begin
                    // the commit reads the shadows as they stood before this edge
                    y_high_ff   <= i_write_data & HIGH3_MASK;
                    cursor_x_ff <= {x_high_shadow_ff[2:0], x_low_shadow_ff};      // [R16]
                    cursor_y_ff <= {i_write_data[2:0], y_low_shadow_ff};          // [R16]
                end
                default: ;
            endcase
        end
    end

    // colour stacks share one pointer; a cursor mode read rewinds it
    assign wr_fg = i_write && (i_index == IDX_CURSOR_FG_STACK);
    assign wr_bg = i_write && (i_index == IDX_CURSOR_BG_STACK);

    always_comb begin
        nxt_stack_ptr = stack_ptr_ff;
        if (wr_fg || wr_bg) begin
            // wraps after the third byte rather than running off the stack
            nxt_stack_ptr = (stack_ptr_ff == STACK_DEPTH_LAST) ? 2'h0
                          : stack_ptr_ff + 2'h1;                                // [R17]
        end
        // the rewind comes last, so a mode read beats a stack write in one cycle
        if (i_read && (i_index == IDX_CURSOR_MODE)) begin
            nxt_stack_ptr = 2'h0;                                         // [R18]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr_ff <= 2'h0;
        end else begin
            stack_ptr_ff <= nxt_stack_ptr;
        end
    end

    // one stack entry per colour byte
    for (genvar g = 0; g < 3; g++) begin : g_stack
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                fg_stack_ff[g] <= BYTE_ZERO;
                bg_stack_ff[g] <= BYTE_ZERO;
            end else begin
                if (wr_fg && stack_ptr_ff == 2'(g)) begin
                    fg_stack_ff[g] <= i_write_data;                       // [R17]
                end
                if (wr_bg && stack_ptr_ff == 2'(g)) begin
                    bg_stack_ff[g] <= i_write_data;                       // [R18]
                end
            end
        end
    end

    // storage start and pattern offsets
    // reserved upper bits are dropped at the write, so reads give zero there
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            start_high_ff  <= BYTE_ZERO;
            start_low_ff   <= BYTE_ZERO;
            pattern_col_ff <= BYTE_ZERO;
            pattern_row_ff <= BYTE_ZERO;
        end else if (i_write) begin
            case (i_index)
                IDX_CURSOR_START_HIGH: start_high_ff  <= i_write_data & HIGH4_MASK;   // [R19]
                IDX_CURSOR_START_LOW:  start_low_ff   <= i_write_data;                // [R19]
                IDX_PATTERN_COL:       pattern_col_ff <= i_write_data & PATTERN_MASK; // [R20]
                IDX_PATTERN_ROW:       pattern_row_ff <= i_write_data & PATTERN_MASK; // [R21]
                default: ;
            endcase
        end
    end

    // read mux; stacks read back the entry under the pointer, reserved bits zero
    // a stack read shows the slot the next write will fill, not the last one
    // written; with no strobe the byte holds
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_read_data <= BYTE_ZERO;
        end else if (i_read) begin
            case (i_index)
                IDX_FIFO_RESTART_LOW:  o_read_data <= fifo_restart_low_ff;
                IDX_INTERLACE_START:   o_read_data <= interlace_start_ff;
                IDX_SYSTEM_CONFIG:     o_read_data <= system_config_ff;
                IDX_FIRMWARE_FLAG:     o_read_data <= firmware_scratch_byte_ff;
                IDX_INTERLACE_MODE:    o_read_data <= interlace_mode_ff;
                IDX_EXTENDED_MODE:     o_read_data <= extended_mode_ff;
                IDX_CURSOR_MODE:       o_read_data <= cursor_mode_ff;
                IDX_CURSOR_X_HIGH:     o_read_data <= x_high_shadow_ff;
                IDX_CURSOR_X_LOW:      o_read_data <= x_low_shadow_ff;
                IDX_CURSOR_Y_HIGH:     o_read_data <= y_high_ff;
                IDX_CURSOR_Y_LOW:      o_read_data <= y_low_shadow_ff;
                IDX_CURSOR_FG_STACK:   o_read_data <= fg_stack_ff[stack_ptr_ff];
                IDX_CURSOR_BG_STACK:   o_read_data <= bg_stack_ff[stack_ptr_ff];
                IDX_CURSOR_START_HIGH: o_read_data <= start_high_ff;
                IDX_CURSOR_START_LOW:  o_read_data <= start_low_ff;
                IDX_PATTERN_COL:       o_read_data <= pattern_col_ff;
                IDX_PATTERN_ROW:       o_read_data <= pattern_row_ff;
                default:               o_read_data <= BYTE_ZERO;
            endcase
        end
    end

    // index decode hit, so the enclosing port can steer its data bus
    // pure decode of the index: it needs no strobe and has no side effect
    always_comb begin
        case (i_index)
            IDX_FIFO_RESTART_LOW, IDX_INTERLACE_START, IDX_SYSTEM_CONFIG,
            IDX_FIRMWARE_FLAG, IDX_INTERLACE_MODE, IDX_EXTENDED_MODE,
            IDX_CURSOR_MODE, IDX_CURSOR_X_HIGH, IDX_CURSOR_X_LOW,
            IDX_CURSOR_Y_HIGH, IDX_CURSOR_Y_LOW, IDX_CURSOR_FG_STACK,
            IDX_CURSOR_BG_STACK, IDX_CURSOR_START_HIGH, IDX_CURSOR_START_LOW,
            IDX_PATTERN_COL, IDX_PATTERN_ROW: o_index_hit = 1'b1;
            default:                          o_index_hit = 1'b0;
        endcase
    end

    // system controls feed the bus front end
    assign o_enhanced_access_enable = system_config_ff[BIT_ENHANCED_ACCESS]; // [R7]
    // high means the front end must insert at least one wait before ready
    assign o_ready_wait_control     = system_config_ff[BIT_READY_WAIT];      // [R8]

    // timing controls; the restart count is in character clocks from display start
    // the restart value always passes; the enable tells the core whether to use it
    assign o_timing.fifo_restart_enable =
        i_compat_control_three_bit4 ;                                          // [R2]
    assign o_timing.fifo_restart =
        {i_horizontal_overflow_ext_bit6, fifo_restart_low_ff};                 // [R1] [R3]
    assign o_timing.interlace_select  = interlace_mode_ff[BIT_INTERLACE_SELECT]; // [R6]
    // offset forced to zero outside interlace so the timing core sees no stale value
    assign o_timing.interlace_start   =
        interlace_mode_ff[BIT_INTERLACE_SELECT] ? interlace_start_ff : BYTE_ZERO; // [R5] [R6]
    assign o_timing.horizontal_double = extended_mode_ff[BIT_HORIZONTAL_DOUBLE]; // [R11]
    // a nonzero width extension field takes over bit 8 of the screen width
    assign o_timing.screen_width_bit8_valid = (i_system_control_two_width == 2'h0); // [R10]
    assign o_timing.screen_width_bit8 = (i_system_control_two_width == 2'h0)
        & extended_mode_ff[BIT_SCREEN_WIDTH_8];                                 // [R10]

    // cursor controls
    // colour words stack entry 2 over entry 1 over entry 0
    assign o_cursor.cursor_enable = cursor_mode_ff[BIT_CURSOR_ENABLE]
        & i_enhanced_mode_active;                                               // [R12]
    assign o_cursor.cursor_right_storage = cursor_mode_ff[BIT_CURSOR_RIGHT];   // [R13]
    assign o_cursor.cursor_x_coord = cursor_x_ff;                              // [R15]
    assign o_cursor.cursor_y_coord = cursor_y_ff;                              // [R16]
    assign o_cursor.foreground = {fg_stack_ff[2], fg_stack_ff[1], fg_stack_ff[0]};
    assign o_cursor.background = {bg_stack_ff[2], bg_stack_ff[1], bg_stack_ff[0]};
    assign o_cursor.cursor_storage_start = {start_high_ff[3:0], start_low_ff}; // [R19]
    assign o_cursor.cursor_pattern_col_offset = pattern_col_ff[5:0];           // [R20]
    assign o_cursor.cursor_pattern_row_offset = pattern_row_ff[5:0];           // [R21]
    // flags a software setup slip; the bank still stores what was written
    assign o_cursor.storage_setup_error = cursor_mode_ff[BIT_CURSOR_RIGHT]
        & (start_low_ff[1:0] != RIGHT_STORE_LOWBITS);                          // [R14]

endmodule

// ==== core/crtc_ext_pkg.sv ====
// package: index map, field positions, reset values and carrier structs of the extended bank
package crtc_ext_pkg;

    // register indices on the index/data port
    localparam logic [7:0] IDX_FIFO_RESTART_LOW  = 8'h3B;
    localparam logic [7:0] IDX_INTERLACE_START   = 8'h3C;
    localparam logic [7:0] IDX_SYSTEM_CONFIG     = 8'h40;
    localparam logic [7:0] IDX_FIRMWARE_FLAG     = 8'h41;
    localparam logic [7:0] IDX_INTERLACE_MODE    = 8'h42;
    localparam logic [7:0] IDX_EXTENDED_MODE     = 8'h43;
    localparam logic [7:0] IDX_CURSOR_MODE       = 8'h45;
    localparam logic [7:0] IDX_CURSOR_X_HIGH     = 8'h46;
    localparam logic [7:0] IDX_CURSOR_X_LOW      = 8'h47;
    localparam logic [7:0] IDX_CURSOR_Y_HIGH     = 8'h48;
    localparam logic [7:0] IDX_CURSOR_Y_LOW      = 8'h49;
    localparam logic [7:0] IDX_CURSOR_FG_STACK   = 8'h4A;
    localparam logic [7:0] IDX_CURSOR_BG_STACK   = 8'h4B;
    localparam logic [7:0] IDX_CURSOR_START_HIGH = 8'h4C;
    localparam logic [7:0] IDX_CURSOR_START_LOW  = 8'h4D;
    localparam logic [7:0] IDX_PATTERN_COL       = 8'h4E;
    localparam logic [7:0] IDX_PATTERN_ROW       = 8'h4F;

    // field positions
    localparam int BIT_FIFO_RESTART_ENABLE = 4;   // in compat_control_three
    localparam int BIT_FIFO_RESTART_MSB    = 6;   // in horizontal_overflow_ext
    localparam int BIT_ENHANCED_ACCESS     = 0;
    localparam int BIT_READY_WAIT          = 4;
    localparam int BIT_INTERLACE_SELECT    = 5;
    localparam int BIT_SCREEN_WIDTH_8      = 2;
    localparam int BIT_HORIZONTAL_DOUBLE   = 7;
    localparam int BIT_CURSOR_ENABLE       = 0;
    localparam int BIT_CURSOR_RIGHT        = 4;
    localparam int WIDTH_EXT_LSB           = 4;   // in system_control_two, bits 5-4

    // writable masks and reset values
    localparam logic [7:0] SYSCFG_RESET       = 8'h30;
    localparam logic [7:0] SYSCFG_RW_MASK     = 8'h11;
    localparam logic [7:0] SYSCFG_FIXED_ONES  = 8'h20;
    localparam logic [7:0] INTERLACE_SELECT_MASK     = 8'h20;
    localparam logic [7:0] EXT_MODE_MASK      = 8'h84;
    localparam logic [7:0] CURSOR_MODE_MASK   = 8'h11;
    localparam logic [7:0] HIGH3_MASK         = 8'h07;
    localparam logic [7:0] HIGH4_MASK         = 8'h0F;
    localparam logic [7:0] PATTERN_MASK       = 8'h3F;
    localparam logic [7:0] BYTE_ZERO          = 8'h00;
    localparam logic [1:0] STACK_DEPTH_LAST   = 2'h2;
    localparam logic [1:0] RIGHT_STORE_LOWBITS = 2'h3;

    // display timing controls handed to the timing core
    typedef struct packed {
        logic        fifo_restart_enable;
        logic [8:0]  fifo_restart;
        logic        interlace_select;
        logic [7:0]  interlace_start;
        logic        horizontal_double;
        logic        screen_width_bit8;
        logic        screen_width_bit8_valid;
    } timing_ctrl_t;

    // cursor controls handed to the cursor pixel generator
    typedef struct packed {
        logic        cursor_enable;
        logic        cursor_right_storage;
        logic [10:0] cursor_x_coord;
        logic [10:0] cursor_y_coord;
        logic [23:0] foreground;
        logic [23:0] background;
        logic [11:0] cursor_storage_start;
        logic [5:0]  cursor_pattern_col_offset;
        logic [5:0]  cursor_pattern_row_offset;
        logic        storage_setup_error;
    } cursor_ctrl_t;

endpackage

// ==== bench/crtc_ext_props.sv ====
// checker: port-level relations of the extended display and cursor register bank
module crtc_ext_props
    import crtc_ext_pkg::*;
(
    input wire logic         i_clock,
    input wire logic         i_resetn,
    input wire logic [7:0]   i_index,
    input wire logic         i_write,
    input wire logic         i_read,
    input wire logic [7:0]   i_write_data,
    input wire logic         i_compat_control_three_bit4,
    input wire logic         i_horizontal_overflow_ext_bit6,
    input wire logic [1:0]   i_system_control_two_width,
    input wire logic         i_enhanced_mode_active,
    input wire logic [7:0]   o_read_data,
    input wire logic         o_index_hit,
    input wire logic         o_enhanced_access_enable,
    input wire logic         o_ready_wait_control,
    input wire timing_ctrl_t o_timing,
    input wire cursor_ctrl_t o_cursor
);
    timeunit 1ns;
    timeprecision 1ns;
    // one clock domain, so clock and disable are stated once
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    restart_low_a: assert property (i_write && i_index == IDX_FIFO_RESTART_LOW
        |=> o_timing.fifo_restart[7:0] == $past(i_write_data))
        else $error("restart low byte not stored");
    restart_gate_a: assert property (
        o_timing.fifo_restart_enable == i_compat_control_three_bit4)
        else $error("restart enable mismatch");
    intl_gate_a: assert property (!o_timing.interlace_select
        |-> o_timing.interlace_start == 8'h00)
        else $error("offset live while noninterlaced");
    syscfg_bits_a: assert property (i_write && i_index == IDX_SYSTEM_CONFIG
        |=> o_enhanced_access_enable == $past(i_write_data[0])
        && o_ready_wait_control == $past(i_write_data[4]))
        else $error("sysconfig bits wrong");
    syscfg_fixed_a: assert property (i_read && i_index == IDX_SYSTEM_CONFIG
        |=> o_read_data[7:5] == 3'h1)
        else $error("sysconfig fixed bits wrong");
    width_gate_a: assert property (i_system_control_two_width != 2'h0
        |-> !o_timing.screen_width_bit8)
        else $error("width bit 8 not ignored");
    cursor_gate_a: assert property (o_cursor.cursor_enable
        |-> i_enhanced_mode_active)
        else $error("cursor shown outside enhanced mode");
    store_flag_a: assert property (o_cursor.storage_setup_error ==
        (o_cursor.cursor_right_storage && o_cursor.cursor_storage_start[1:0] != 2'h3))
        else $error("storage flag wrong");
    pos_hold_a: assert property (!(i_write && i_index == IDX_CURSOR_Y_HIGH)
        |=> $stable(o_cursor.cursor_x_coord) && $stable(o_cursor.cursor_y_coord))
        else $error("position moved without commit");
    ptr_clear_a: assert property ((i_read && i_index == IDX_CURSOR_MODE)
        ##1 !(i_write && (i_index == IDX_CURSOR_FG_STACK || i_index == IDX_CURSOR_BG_STACK))
        ##1 (i_write && i_index == IDX_CURSOR_FG_STACK)
        |=> o_cursor.foreground[7:0] == $past(i_write_data))
        else $error("pointer not cleared by mode read");
    unmapped_read_a: assert property (i_read && !o_index_hit |=> o_read_data == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind crtc_extended_cursor_regs crtc_ext_props u_props (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_index(i_index), .i_write(i_write),
    .i_read(i_read), .i_write_data(i_write_data),
    .i_compat_control_three_bit4(i_compat_control_three_bit4),
    .i_horizontal_overflow_ext_bit6(i_horizontal_overflow_ext_bit6),
    .i_system_control_two_width(i_system_control_two_width),
    .i_enhanced_mode_active(i_enhanced_mode_active), .o_read_data(o_read_data),
    .o_index_hit(o_index_hit), .o_enhanced_access_enable(o_enhanced_access_enable),
    .o_ready_wait_control(o_ready_wait_control), .o_timing(o_timing), .o_cursor(o_cursor)
);

// ==== bench/crtc_extended_cursor_regs_bench.sv ====
// testbench: directed scenarios for the extended display and cursor register bank
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module crtc_extended_cursor_regs_bench
    import crtc_ext_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         i_clock = 1'b0, i_resetn = 1'b0, i_write = 1'b0, i_read = 1'b0;
    logic [7:0]   i_index = 8'h00, i_write_data = 8'h00;
    logic         i_compat_control_three_bit4 = 1'b0, i_horizontal_overflow_ext_bit6 = 1'b0;
    logic [1:0]   i_system_control_two_width = 2'h0;
    logic         i_enhanced_mode_active = 1'b0;
    logic [7:0]   o_read_data;
    logic         o_index_hit, o_enhanced_access_enable, o_ready_wait_control;
    timing_ctrl_t o_timing;
    cursor_ctrl_t o_cursor;
    int           errors = 0;
    int           n_compared = 0;

    always #20 i_clock = ~i_clock;

    crtc_extended_cursor_regs DUT (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_index(i_index), .i_write(i_write),
        .i_read(i_read), .i_write_data(i_write_data),
        .i_compat_control_three_bit4(i_compat_control_three_bit4),
        .i_horizontal_overflow_ext_bit6(i_horizontal_overflow_ext_bit6),
        .i_system_control_two_width(i_system_control_two_width),
        .i_enhanced_mode_active(i_enhanced_mode_active), .i_eight_bpp(1'b0),
        .o_read_data(o_read_data), .o_index_hit(o_index_hit),
        .o_enhanced_access_enable(o_enhanced_access_enable),
        .o_ready_wait_control(o_ready_wait_control), .o_timing(o_timing), .o_cursor(o_cursor)
    );

    // each access starts on a rising edge and ends at the falling edge after the next rising edge,
    // so the strobe is never raised and lowered in the same time step
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_clock);
        i_index <= idx; i_write_data <= d; i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        @(negedge i_clock);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge i_clock);
        i_index <= idx; i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        @(negedge i_clock);
        `CHK(o_read_data, exp)
    endtask

    task automatic t_reset();
        logic [7:0] idx [10] = '{8'h3B, 8'h3C, 8'h40, 8'h41, 8'h42,
                                 8'h43, 8'h45, 8'h46, 8'h47, 8'h44};
        for (int k = 0; k < 10; k++) begin
            rdc(idx[k], (idx[k] == 8'h40) ? 8'h30 : 8'h00);
        end
        `CHK(o_index_hit, 1'b0) // index 0x44 is a hole in the map
        $display("test reset values done");
    endtask

    task automatic t_sysconfig();
        wr(IDX_SYSTEM_CONFIG, 8'hFF);
        rdc(IDX_SYSTEM_CONFIG, 8'h31);
        `CHK({o_enhanced_access_enable, o_ready_wait_control}, 2'h3)
        wr(IDX_SYSTEM_CONFIG, 8'h00);
        rdc(IDX_SYSTEM_CONFIG, 8'h20);
        `CHK({o_enhanced_access_enable, o_ready_wait_control}, 2'h0)
        wr(IDX_FIRMWARE_FLAG, 8'hA5);
        rdc(IDX_FIRMWARE_FLAG, 8'hA5);
        $display("test system configuration done");
    endtask

    task automatic t_timing();
        wr(IDX_FIFO_RESTART_LOW, 8'hA5); // a blanking-period value, as software must
        `CHK(o_timing.fifo_restart_enable, 1'b0)
        @(posedge i_clock);
        i_horizontal_overflow_ext_bit6 <= 1'b1;
        i_compat_control_three_bit4 <= 1'b1;
        @(negedge i_clock);
        `CHK(o_timing.fifo_restart, 9'h1A5)
        `CHK(o_timing.fifo_restart_enable, 1'b1)
        wr(IDX_INTERLACE_START, 8'h5A);
        `CHK(o_timing.interlace_start, 8'h00)
        wr(IDX_INTERLACE_MODE, 8'hFF);
        rdc(IDX_INTERLACE_MODE, 8'h20);
        `CHK(o_timing.interlace_select, 1'b1)
        `CHK(o_timing.interlace_start, 8'h5A)
        wr(IDX_EXTENDED_MODE, 8'hFF);
        rdc(IDX_EXTENDED_MODE, 8'h84);
        `CHK({o_timing.horizontal_double, o_timing.screen_width_bit8}, 2'h3)
        `CHK(o_timing.screen_width_bit8_valid, 1'b1)
        @(posedge i_clock);
        i_system_control_two_width <= 2'h1;
        @(negedge i_clock);
        `CHK({o_timing.screen_width_bit8, o_timing.screen_width_bit8_valid}, 2'h0)
        $display("test timing controls done");
    endtask

    task automatic t_position();
        wr(IDX_CURSOR_X_HIGH, 8'hFF);
        wr(IDX_CURSOR_X_LOW, 8'h34);
        wr(IDX_CURSOR_Y_LOW, 8'h56);
        rdc(IDX_CURSOR_X_HIGH, 8'h07);
        `CHK(o_cursor.cursor_x_coord, 11'h000)
        wr(IDX_CURSOR_Y_HIGH, 8'hFA);
        `CHK({o_cursor.cursor_x_coord, o_cursor.cursor_y_coord}, {11'h734, 11'h256})
        $display("test cursor position done");
    endtask

    task automatic t_colour();
        rdc(IDX_CURSOR_MODE, 8'h00);
        wr(IDX_CURSOR_FG_STACK, 8'h11);
        wr(IDX_CURSOR_FG_STACK, 8'h22);
        wr(IDX_CURSOR_FG_STACK, 8'h33);
        wr(IDX_CURSOR_BG_STACK, 8'h44);
        wr(IDX_CURSOR_BG_STACK, 8'h55);
        wr(IDX_CURSOR_BG_STACK, 8'h66);
        `CHK(o_cursor.foreground, 24'h332211)
        `CHK(o_cursor.background, 24'h665544)
        wr(IDX_CURSOR_FG_STACK, 8'h77);
        rdc(IDX_CURSOR_MODE, 8'h00);
        wr(IDX_CURSOR_BG_STACK, 8'h88);
        `CHK(o_cursor.background, 24'h665588)
        $display("test colour stacks done");
    endtask

    task automatic t_cursor();
        wr(IDX_CURSOR_MODE, 8'hFF);
        rdc(IDX_CURSOR_MODE, 8'h11);
        `CHK(o_cursor.cursor_enable, 1'b0)
        @(posedge i_clock);
        i_enhanced_mode_active <= 1'b1;
        @(negedge i_clock);
        `CHK({o_cursor.cursor_enable, o_cursor.cursor_right_storage}, 2'h3)
        wr(IDX_CURSOR_START_HIGH, 8'hFF);
        wr(IDX_CURSOR_START_LOW, 8'h10);
        `CHK({o_cursor.cursor_storage_start, o_cursor.storage_setup_error},
             {12'hF10, 1'b1})
        wr(IDX_CURSOR_START_LOW, 8'h13);
        `CHK(o_cursor.storage_setup_error, 1'b0)
        wr(IDX_PATTERN_COL, 8'hFF);
        wr(IDX_PATTERN_ROW, 8'hC5);
        rdc(IDX_PATTERN_COL, 8'h3F);
        `CHK(o_cursor.cursor_pattern_row_offset, 6'h05)
        $display("test cursor controls done");
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // the tests need well under 500 cycles; a hang is cut off by the watchdog at 3000 cycles, far above that
    initial begin
        repeat (3000) @(posedge i_clock);
        errors++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        t_reset();
        t_sysconfig();
        t_timing();
        t_position();
        t_colour();
        t_cursor();
        conclude();
    end
endmodule
